// ---- rhgs_pkg.sv ----
// Purpose: constants and carrier types for the root hub global status register
// Assumes: 32-bit register reached by 8-bit command codes on the processor bus
// Notes: two downstream ports, numbered 1 and 2; bit 0 of port vectors unused
`default_nettype none
package rhgs_pkg;
  // command codes; write code is the read code with the top bit set
  localparam logic [7:0] RHGS_CODE_RD = 8'h14;
  localparam logic [7:0] RHGS_CODE_WR = 8'h94;
  // field positions
  localparam int RHGS_BIT_CLR_WAKE = 31;
  localparam int RHGS_BIT_OC_CHANGE = 17;
  localparam int RHGS_BIT_SET_POWER = 16;
  localparam int RHGS_BIT_WAKE_EN = 15;
  localparam int RHGS_BIT_OC_IND = 1;
  localparam int RHGS_BIT_CLR_POWER = 0;
  // port count and reset values
  localparam int RHGS_NPORTS = 2;
  localparam logic RHGS_WAKE_RESET = 1'b0;
  localparam logic RHGS_FLAG_RESET = 1'b0;
  localparam logic [RHGS_NPORTS:0] RHGS_POWER_RESET = 3'h0;
  localparam logic [31:0] RHGS_DATA_RESET = 32'h0000_0000;

  // one command cycle from the processor bus
  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [31:0] data;
  } rhgs_cmd_s;

  // read answer
  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } rhgs_rsp_s;
endpackage : rhgs_pkg
`default_nettype wire

// ---- rhgs_root_hub_global_status.sv ----
// Purpose: hub-wide status and command register of the root hub
// Assumes: single clk at 20 MHz, synchronous active-high reset
// Notes: global overcurrent pin is asynchronous and is synchronised here
// Operation
// - write one clears remote wakeup enable
// - overcurrent indicator change sets change flag
// - one write clears change flag, zero ignored
// - local power bits always read zero
// - global mode set power powers all ports
// - per-port mode set power only unmasked ports
// - global mode clear power unpowers all ports
// - per-port mode clear power only unmasked ports
// - wakeup enable lets connect change resume
// - write one sets remote wakeup enable
// - indicator reads one during overcurrent
// - per-port overcurrent reporting forces indicator zero
// - zero writes to command bits change nothing
// - in per-port mode masked ports ignore global power commands
// - separate read and write command codes
`default_nettype none
module rhgs_root_hub_global_status
  import rhgs_pkg::*;
(
  input wire logic clk, // 20 MHz controller clock
  input wire logic reset, // synchronous, active high
  input wire rhgs_cmd_s cmd, // command cycle from processor bus
  output rhgs_rsp_s rsp, // read answer, one cycle after read code
  input wire logic overcurrent_pin, // global overcurrent sense, async
  input wire logic per_port_oc_select, // overcurrent reported per port
  input wire logic per_port_switching_select, // per-port power mode
  input wire logic [RHGS_NPORTS:0] port_power_mask, // bit 0 unused
  input wire logic port_connect_change, // any port connect change, pulse
  input wire logic suspended_state, // controller is suspended
  output logic [RHGS_NPORTS:0] port_power_state, // bit 0 reads zero
  output logic remote_wakeup_enable, // wakeup enable state
  output logic resuming_state, // one-cycle request to leave suspend
  output logic resume_seen_interrupt // one-cycle interrupt event
);
  logic oc_meta_reg, oc_sync_reg;
  logic oc_ind_reg, oc_ind_next;
  logic oc_flag_reg, oc_flag_next;
  logic wake_reg, wake_next;
  logic [RHGS_NPORTS:0] power_reg, power_next;
  logic resume_reg, resume_next;
  rhgs_rsp_s rsp_reg, rsp_next;
  logic wr, rd;

  // pin synchroniser; meta stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (reset) begin
      oc_meta_reg <= 1'b0;
      oc_sync_reg <= 1'b0;
    end else begin
      oc_meta_reg <= overcurrent_pin;
      oc_sync_reg <= oc_meta_reg;
    end
  end

  // code decode
  // any other code falls through, so it neither answers nor writes
  assign wr = cmd.valid && (cmd.code == RHGS_CODE_WR);
  assign rd = cmd.valid && (cmd.code == RHGS_CODE_RD);

  // status flags and wakeup enable
  always_comb begin
    oc_ind_next = oc_sync_reg && !per_port_oc_select;
    oc_flag_next = oc_flag_reg;
    if (wr && cmd.data[RHGS_BIT_OC_CHANGE]) begin
      oc_flag_next = 1'b0;
    end
    // set placed last so it wins over the clear
    if (oc_ind_next != oc_ind_reg) begin
      oc_flag_next = 1'b1;
    end
    wake_next = wake_reg;
    if (wr && cmd.data[RHGS_BIT_WAKE_EN]) begin
      wake_next = 1'b1;
    end
    if (wr && cmd.data[RHGS_BIT_CLR_WAKE]) begin
      wake_next = 1'b0;
    end
    // connect change resumes only when enabled
    // a bare pulse; the suspend logic outside acts on it and holds state
    resume_next = wake_reg && suspended_state && port_connect_change;
  end

  // per-port power switching, one slice per port
  // clear wins over set so a confused write leaves ports unpowered
  assign power_next[0] = 1'b0;
  for (genvar p = 1; p <= RHGS_NPORTS; p++) begin : g_port
    logic follows_global;
    // masked ports ignore global commands in per-port mode
    assign follows_global = !per_port_switching_select || !port_power_mask[p];
    always_comb begin
      power_next[p] = power_reg[p];
      if (wr && follows_global && cmd.data[RHGS_BIT_SET_POWER]) begin
        power_next[p] = 1'b1;
      end
      // clear power, only unmasked in per-port mode; clear wins if both written
      if (wr && follows_global && cmd.data[RHGS_BIT_CLR_POWER]) begin
        power_next[p] = 1'b0;
      end
    end
  end

  // read answer assembly
  // reserved bits read zero because the word starts from all zeros
  always_comb begin
    rsp_next.valid = rd;
    rsp_next.data = RHGS_DATA_RESET;
    if (rd) begin
      // local power bits 0 and 16 stay zero
      rsp_next.data[RHGS_BIT_OC_CHANGE] = oc_flag_reg;
      rsp_next.data[RHGS_BIT_WAKE_EN] = wake_reg;
      rsp_next.data[RHGS_BIT_OC_IND] = oc_ind_reg;
    end
  end

  // state registers, all on clk so updates are synchronous
  // reset branch holds constants only, keeping the reset path free of logic
  always_ff @(posedge clk) begin
    if (reset) begin
      oc_ind_reg <= RHGS_FLAG_RESET;
      oc_flag_reg <= RHGS_FLAG_RESET;
      wake_reg <= RHGS_WAKE_RESET;
      power_reg <= RHGS_POWER_RESET;
      resume_reg <= 1'b0;
      rsp_reg <= '0;
    end else begin
      oc_ind_reg <= oc_ind_next;
      oc_flag_reg <= oc_flag_next;
      wake_reg <= wake_next;
      power_reg <= power_next;
      resume_reg <= resume_next;
      rsp_reg <= rsp_next;
    end
  end

  assign rsp = rsp_reg;
  assign port_power_state = power_reg;
  assign remote_wakeup_enable = wake_reg;
  assign resuming_state = resume_reg;
  assign resume_seen_interrupt = resume_reg;

  // flag, wakeup, power, indicator and read checks
  wake_clear_a: assert property (@(posedge clk) disable iff (reset)
    wr && cmd.data[RHGS_BIT_CLR_WAKE] |=> !wake_reg)
    else $error("wakeup enable not cleared");
  flag_set_a: assert property (@(posedge clk) disable iff (reset)
    $changed(oc_ind_reg) |-> oc_flag_reg)
    else $error("change flag missed indicator change");
  flag_clear_a: assert property (@(posedge clk) disable iff (reset)
    $fell(oc_flag_reg) |-> $past(wr && cmd.data[RHGS_BIT_OC_CHANGE]))
    else $error("change flag dropped without clear");
  local_zero_a: assert property (@(posedge clk) disable iff (reset)
    rsp.valid |-> !rsp.data[RHGS_BIT_SET_POWER] && !rsp.data[RHGS_BIT_CLR_POWER])
    else $error("local power bit read nonzero");
  power_on_a: assert property (@(posedge clk) disable iff (reset)
    wr && !per_port_switching_select && cmd.data[RHGS_BIT_SET_POWER]
    && !cmd.data[RHGS_BIT_CLR_POWER] |=> &port_power_state[RHGS_NPORTS:1])
    else $error("global power on failed");
  mask_hold_a: assert property (@(posedge clk) disable iff (reset)
    per_port_switching_select && port_power_mask[1] |=> $stable(port_power_state[1]))
    else $error("masked port changed by global command");
  power_off_a: assert property (@(posedge clk) disable iff (reset)
    wr && !per_port_switching_select && cmd.data[RHGS_BIT_CLR_POWER]
    |=> port_power_state == RHGS_POWER_RESET)
    else $error("global power off failed");
  resume_gate_a: assert property (@(posedge clk) disable iff (reset)
    resume_seen_interrupt |-> $past(wake_reg) && $past(port_connect_change))
    else $error("resume without wakeup enable");
  wake_set_a: assert property (@(posedge clk) disable iff (reset)
    wr && cmd.data[RHGS_BIT_WAKE_EN] && !cmd.data[RHGS_BIT_CLR_WAKE] |=> wake_reg)
    else $error("wakeup enable not set");
  ind_mask_a: assert property (@(posedge clk) disable iff (reset)
    per_port_oc_select |=> !oc_ind_reg)
    else $error("indicator set in per-port reporting");
  read_ans_a: assert property (@(posedge clk) disable iff (reset)
    rd |=> rsp.valid && rsp.data[RHGS_BIT_WAKE_EN] == $past(wake_reg))
    else $error("read answer wrong");
  zero_write_a: assert property (@(posedge clk) disable iff (reset)
    wr && cmd.data == RHGS_DATA_RESET && !port_connect_change
    |=> $stable(wake_reg) && $stable(port_power_state))
    else $error("zero write changed state");

  // power switching checks for the unmasked port
  power_unmask_on_a: assert property (@(posedge clk) disable iff (reset)
    wr && per_port_switching_select && !port_power_mask[2] && cmd.data[RHGS_BIT_SET_POWER]
    && !cmd.data[RHGS_BIT_CLR_POWER] |=> port_power_state[2])
    else $error("unmasked port not powered");
  power_unmask_off_a: assert property (@(posedge clk) disable iff (reset)
    wr && per_port_switching_select && !port_power_mask[2] && cmd.data[RHGS_BIT_CLR_POWER]
    |=> !port_power_state[2])
    else $error("unmasked port not unpowered");

  // indicator, flag and resume checks
  ind_high_a: assert property (@(posedge clk) disable iff (reset)
    oc_sync_reg && !per_port_oc_select |=> oc_ind_reg)
    else $error("indicator low during overcurrent");
  ind_low_a: assert property (@(posedge clk) disable iff (reset)
    !oc_sync_reg |=> !oc_ind_reg)
    else $error("indicator high without overcurrent");
  set_wins_a: assert property (@(posedge clk) disable iff (reset)
    wr && cmd.data[RHGS_BIT_OC_CHANGE] ##1 $changed(oc_ind_reg) |-> oc_flag_reg)
    else $error("clear beat simultaneous flag set");
  resume_block_a: assert property (@(posedge clk) disable iff (reset)
    !wake_reg || !suspended_state |=> !resume_seen_interrupt)
    else $error("resume while disabled or awake");

  // the answer word is quiet between reads
  read_idle_a: assert property (@(posedge clk) disable iff (reset)
    !rsp.valid |-> rsp.data == RHGS_DATA_RESET)
    else $error("answer data outside a read");
endmodule : rhgs_root_hub_global_status
`default_nettype wire

// ---- testbench.sv ----
// Purpose: self-checking bench for the root hub global status register
// Assumes: inputs change on the falling edge, outputs sampled one edge later
// Notes: overcurrent latency of three edges comes from the two synchroniser stages and the indicator register
`default_nettype none
module testbench;
  import rhgs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset = 1'b1;
  rhgs_cmd_s cmd = '0;
  rhgs_rsp_s rsp;
  logic oc = 1'b0, ppoc = 1'b0, pps = 1'b0, cc = 1'b0, susp = 1'b0;
  logic [RHGS_NPORTS:0] mask = 3'h0;
  logic [RHGS_NPORTS:0] pwr;
  logic wake, res_req, res_irq;
  int n_errors = 0;
  int cmp_count = 0;
  rhgs_root_hub_global_status rhgs_root_hub_global_status_inst (.clk(clk), .reset(reset),
    .cmd(cmd), .rsp(rsp), .overcurrent_pin(oc), .per_port_oc_select(ppoc),
    .per_port_switching_select(pps), .port_power_mask(mask), .port_connect_change(cc),
    .suspended_state(susp), .port_power_state(pwr), .remote_wakeup_enable(wake),
    .resuming_state(res_req), .resume_seen_interrupt(res_irq));
  // 50 ns clock
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : ck
  // one command cycle; returns at the falling edge after the taking edge
  // callers keep reserved bits zero
  task automatic cmdc(input logic [7:0] c, input logic [31:0] d);
    @(negedge clk);
    cmd = '{1'b1, c, d};
    @(negedge clk);
    cmd.valid = 1'b0;
  endtask : cmdc
  task automatic rdck(input logic [31:0] e);
    cmdc(RHGS_CODE_RD, 32'h0);
    ck(32'(rsp.valid), 32'h1);
    ck(rsp.data, e);
  endtask : rdck
  task automatic t_wake();
    cmdc(RHGS_CODE_WR, 32'h0000_8000);
    ck(32'(wake), 32'h1);
    cmdc(RHGS_CODE_WR, 32'h0);
    ck(32'(wake), 32'h1);
    rdck(32'h0000_8000);
    cmdc(RHGS_CODE_WR, 32'h8000_0000);
    ck(32'(wake), 32'h0);
  endtask : t_wake
  // a foreign code must neither answer nor write
  task automatic t_code();
    cmdc(8'h13, 32'h0000_8000);
    ck({rsp.valid, 30'h0, wake}, 32'h0);
  endtask : t_code
  task automatic t_power();
    mask = 3'h6;
    cmdc(RHGS_CODE_WR, 32'h0001_0000);
    ck(32'(pwr), 32'h6);
    rdck(32'h0);
    cmdc(RHGS_CODE_WR, 32'h0000_0001);
    ck(32'(pwr), 32'h0);
    pps = 1'b1;
    mask = 3'h2;
    cmdc(RHGS_CODE_WR, 32'h0001_0000);
    ck(32'(pwr), 32'h4);
    pps = 1'b0;
    cmdc(RHGS_CODE_WR, 32'h0001_0000);
    pps = 1'b1;
    cmdc(RHGS_CODE_WR, 32'h0000_0001);
    ck(32'(pwr), 32'h2);
  endtask : t_power
  task automatic t_oc();
    oc = 1'b1;
    repeat (4) @(negedge clk);
    rdck(32'h0002_0002);
    cmdc(RHGS_CODE_WR, 32'h0);
    rdck(32'h0002_0002);
    cmdc(RHGS_CODE_WR, 32'h0002_0000);
    rdck(32'h0000_0002);
    ppoc = 1'b1;
    repeat (2) @(negedge clk);
    rdck(32'h0002_0000);
    // indicator change and a flag clear land on one edge; the set must win
    @(negedge clk);
    ppoc = 1'b0;
    cmd = '{1'b1, RHGS_CODE_WR, 32'h0002_0000};
    @(negedge clk);
    cmd.valid = 1'b0;
    rdck(32'h0002_0002);
  endtask : t_oc
  // connect change while suspended, with and without the enable
  task automatic t_resume();
    susp = 1'b1;
    cmdc(RHGS_CODE_WR, 32'h0000_8000);
    cc = 1'b1;
    @(negedge clk);
    cc = 1'b0;
    ck({res_req, res_irq}, 32'h3);
    @(negedge clk);
    ck({res_req, res_irq}, 32'h0);
    // enabled but awake: a connect change must not resume
    susp = 1'b0;
    cc = 1'b1;
    @(negedge clk);
    cc = 1'b0;
    ck({res_req, res_irq}, 32'h0);
    susp = 1'b1;
    cmdc(RHGS_CODE_WR, 32'h8000_0000);
    cc = 1'b1;
    @(negedge clk);
    cc = 1'b0;
    ck({res_req, res_irq}, 32'h0);
  endtask : t_resume
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  // watchdog against a hung sequence
  initial begin
    repeat (2000) @(posedge clk);
    n_errors++;
    summarize();
  end
  initial begin
    repeat (2) @(negedge clk);
    reset = 1'b0;
    ck({29'h0, pwr}, 32'h0);
    rdck(32'h0);
    t_wake();
    t_code();
    t_power();
    t_oc();
    t_resume();
    summarize();
  end
endmodule : testbench
`default_nettype wire
